// >>> src/ipt_pkg.sv
// constants and types for the two-wire potentiometer command slave
package ipt_pkg;

  // ----------------------------------------------------------------
  // address byte
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_FIXED   = 5'h0b;   // 0 1 0 1 1
  localparam int         ADDR_RW_POS  = 0;

  // ----------------------------------------------------------------
  // instruction byte fields
  // ----------------------------------------------------------------
  localparam int INSTR_SEL_POS = 7;
  localparam int INSTR_RS_POS  = 6;
  localparam int INSTR_SD_POS  = 5;
  localparam int INSTR_O1_POS  = 4;
  localparam int INSTR_O2_POS  = 3;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] WIPER_MIDSCALE = 8'h80;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam int         SYNC_STAGES    = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sel;
    logic rs;
    logic sd;
    logic o1;
    logic o2;
  } ipt_instr_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } ipt_bus_evt_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_ADDR   = 4'h1,
    ST_A_ACK  = 4'h3,
    ST_INSTR  = 4'h2,
    ST_I_ACK  = 4'h6,
    ST_DATA   = 4'h7,
    ST_D_ACK  = 4'h5,
    ST_RD     = 4'h4,
    ST_RD_ACK = 4'hc,
    ST_IGNORE = 4'h8
  } ipt_state_t;

  localparam ipt_instr_t INSTR_RESET = '{sel: 1'b0, rs: 1'b0, sd: 1'b0, o1: 1'b0, o2: 1'b0};

endpackage

// >>> src/ipt_pot_slave.sv
// two-wire serial slave front end of a dual 256-step potentiometer
`timescale 1ns/100ps

// Functional notes
// - start, address, instruction, data, stop; ack each
// - respond only when strap bits match address
// - last address bit: high read, low write
// - first instruction bit picks wiper register
// - midscale-reset bit forces selected wiper midscale
// - shutdown bit acts like inverted shutdown pin
// - logic-output bits latched onto output pins
// - read returns last selected wiper, MSB first
module ipt_pot_slave (
  // clock, reset, enable
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       en_in,
  // serial bus, open drain data
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  // strap and control pins
  input  wire logic       addr_strap_hi_in,
  input  wire logic       addr_strap_lo_in,
  input  wire logic       shutdown_pin_n_in,
  // device outputs
  output logic [7:0]      wiper_reg_1_out,
  output logic [7:0]      wiper_reg_2_out,
  output logic            logic_out_1_out,
  output logic            logic_out_2_out,
  output logic            shutdown_out
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [ipt_pkg::SYNC_STAGES-1:0] scl_s_q, scl_s_d;
  logic [ipt_pkg::SYNC_STAGES-1:0] sda_s_q, sda_s_d;
  logic [ipt_pkg::SYNC_STAGES-1:0] shd_s_q, shd_s_d;
  logic [ipt_pkg::SYNC_STAGES-1:0] ahi_s_q, ahi_s_d;
  logic [ipt_pkg::SYNC_STAGES-1:0] alo_s_q, alo_s_d;
  logic                            scl_p_q, scl_p_d;
  logic                            sda_p_q, sda_p_d;

  always_comb begin
    scl_s_d = {scl_s_q[0], scl_in};
    sda_s_d = {sda_s_q[0], sda_in};
    shd_s_d = {shd_s_q[0], shutdown_pin_n_in};
    ahi_s_d = {ahi_s_q[0], addr_strap_hi_in};
    alo_s_d = {alo_s_q[0], addr_strap_lo_in};
    scl_p_d = scl_s_q[1];
    sda_p_d = sda_s_q[1];
  end

  // idle bus is high on both lines, so reset there to avoid a false start
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_s_q <= '1;
      sda_s_q <= '1;
      shd_s_q <= '1;
      ahi_s_q <= '0;
      alo_s_q <= '0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (en_in) begin
      scl_s_q <= scl_s_d;
      sda_s_q <= sda_s_d;
      shd_s_q <= shd_s_d;
      ahi_s_q <= ahi_s_d;
      alo_s_q <= alo_s_d;
      scl_p_q <= scl_p_d;
      sda_p_q <= sda_p_d;
    end
  end

  ipt_pkg::ipt_bus_evt_t evt;
  logic                  scl_w;
  logic                  sda_w;

  assign scl_w     = scl_s_q[1];
  assign sda_w     = sda_s_q[1];
  assign evt.start = scl_w & scl_p_q & sda_p_q & ~sda_w;
  assign evt.stop  = scl_w & scl_p_q & ~sda_p_q & sda_w;
  assign evt.rise  = scl_w & ~scl_p_q;
  assign evt.fall  = ~scl_w & scl_p_q;

  // ----------------------------------------------------------------
  // protocol engine and device state
  // ----------------------------------------------------------------
  ipt_pkg::ipt_state_t state_q, state_d;
  logic [2:0]          cnt_q, cnt_d;
  logic [7:0]          sh_q, sh_d;
  logic                ph_q, ph_d;
  logic                rw_q, rw_d;
  logic                oe_q, oe_d;
  logic                sda_o_q;
  ipt_pkg::ipt_instr_t ins_q, ins_d;
  logic [7:0]          wiper_q [2];
  logic [7:0]          wiper_d [2];
  logic                shut_q, shut_d;
  logic [7:0]          byte_in;
  logic [7:0]          rd_byte;

  assign byte_in = {sh_q[6:0], sda_w};
  assign rd_byte = wiper_q[ins_q.sel];

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    ph_d    = ph_q;
    rw_d    = rw_q;
    oe_d    = oe_q;
    ins_d   = ins_q;
    wiper_d = wiper_q;
    shut_d  = ins_q.sd | ~shd_s_q[1];
    if (evt.start) begin
      state_d = ipt_pkg::ST_ADDR;
      cnt_d   = '0;
      ph_d    = 1'b0;
      oe_d    = 1'b0;
    end else if (evt.stop) begin
      state_d = ipt_pkg::ST_IDLE;
      oe_d    = 1'b0;
    end else begin
      unique case (state_q)
        ipt_pkg::ST_IDLE, ipt_pkg::ST_IGNORE: begin
          oe_d = 1'b0;
        end
        ipt_pkg::ST_ADDR, ipt_pkg::ST_INSTR, ipt_pkg::ST_DATA: begin
          if (evt.rise) begin
            sh_d  = byte_in;
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == ipt_pkg::BIT_LAST) begin
              ph_d = 1'b0;
              if (state_q == ipt_pkg::ST_ADDR) begin
                if (byte_in[7:1] == {ipt_pkg::ADDR_FIXED, ahi_s_q[1], alo_s_q[1]}) begin
                  rw_d    = byte_in[ipt_pkg::ADDR_RW_POS];
                  state_d = ipt_pkg::ST_A_ACK;
                end else begin
                  state_d = ipt_pkg::ST_IGNORE;
                end
              end else if (state_q == ipt_pkg::ST_INSTR) begin
                ins_d.sel = byte_in[ipt_pkg::INSTR_SEL_POS];
                ins_d.rs  = byte_in[ipt_pkg::INSTR_RS_POS];
                ins_d.sd  = byte_in[ipt_pkg::INSTR_SD_POS];
                ins_d.o1  = byte_in[ipt_pkg::INSTR_O1_POS];
                ins_d.o2  = byte_in[ipt_pkg::INSTR_O2_POS];
                if (byte_in[ipt_pkg::INSTR_RS_POS]) begin
                  wiper_d[byte_in[ipt_pkg::INSTR_SEL_POS]] = ipt_pkg::WIPER_MIDSCALE;
                end
                state_d = ipt_pkg::ST_I_ACK;
              end else begin
                // midscale reset owns this transfer; data byte acked, not stored
                if (!ins_q.rs) begin
                  wiper_d[ins_q.sel] = byte_in;
                end
                state_d = ipt_pkg::ST_D_ACK;
              end
            end
          end
        end
        ipt_pkg::ST_A_ACK, ipt_pkg::ST_I_ACK, ipt_pkg::ST_D_ACK: begin
          if (evt.fall) begin
            if (!ph_q) begin
              oe_d = 1'b1;
              ph_d = 1'b1;
            end else begin
              ph_d  = 1'b0;
              cnt_d = '0;
              oe_d  = 1'b0;
              if (state_q == ipt_pkg::ST_A_ACK && rw_q) begin
                sh_d    = rd_byte;
                oe_d    = ~rd_byte[7];
                state_d = ipt_pkg::ST_RD;
              end else if (state_q == ipt_pkg::ST_A_ACK) begin
                state_d = ipt_pkg::ST_INSTR;
              end else begin
                state_d = ipt_pkg::ST_DATA;
              end
            end
          end
        end
        ipt_pkg::ST_RD: begin
          if (evt.fall) begin
            if (cnt_q == ipt_pkg::BIT_LAST) begin
              oe_d    = 1'b0;
              ph_d    = 1'b0;
              state_d = ipt_pkg::ST_RD_ACK;
            end else begin
              cnt_d = cnt_q + 3'h1;
              sh_d  = {sh_q[6:0], 1'b0};
              oe_d  = ~sh_q[6];
            end
          end
        end
        ipt_pkg::ST_RD_ACK: begin
          if (evt.rise) begin
            ph_d = ~sda_w;
          end else if (evt.fall) begin
            cnt_d = '0;
            if (ph_q) begin
              sh_d    = rd_byte;
              oe_d    = ~rd_byte[7];
              state_d = ipt_pkg::ST_RD;
            end else begin
              state_d = ipt_pkg::ST_IGNORE;
            end
          end
        end
        default: begin
          state_d = ipt_pkg::ST_IDLE;
          oe_d    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q    <= ipt_pkg::ST_IDLE;
      cnt_q      <= '0;
      sh_q       <= '0;
      ph_q       <= 1'b0;
      rw_q       <= 1'b0;
      oe_q       <= 1'b0;
      sda_o_q    <= 1'b0;
      ins_q      <= ipt_pkg::INSTR_RESET;
      wiper_q[0] <= ipt_pkg::WIPER_MIDSCALE;
      wiper_q[1] <= ipt_pkg::WIPER_MIDSCALE;
      shut_q     <= 1'b0;
    end else if (en_in) begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      sh_q       <= sh_d;
      ph_q       <= ph_d;
      rw_q       <= rw_d;
      oe_q       <= oe_d;
      sda_o_q    <= 1'b0;
      ins_q      <= ins_d;
      wiper_q[0] <= wiper_d[0];
      wiper_q[1] <= wiper_d[1];
      shut_q     <= shut_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign sda_out         = sda_o_q;
  assign sda_oe_out      = oe_q;
  assign wiper_reg_1_out = wiper_q[0];
  assign wiper_reg_2_out = wiper_q[1];
  assign logic_out_1_out = ins_q.o1;
  assign logic_out_2_out = ins_q.o2;
  assign shutdown_out    = shut_q;

endmodule

// >>> test/ipt_pot_slave_sva.sv
// bound assertion checker for the potentiometer command slave
`timescale 1ns/100ps
module ipt_pot_slave_sva (
  // clock, reset, enable
  input wire logic       clk_in,
  input wire logic       nrst_in,
  input wire logic       en_in,
  // serial bus
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  // straps and pins
  input wire logic       addr_strap_hi_in,
  input wire logic       addr_strap_lo_in,
  input wire logic       shutdown_pin_n_in,
  // device outputs
  input wire logic [7:0] wiper_reg_1_out,
  input wire logic [7:0] wiper_reg_2_out,
  input wire logic       logic_out_1_out,
  input wire logic       logic_out_2_out,
  input wire logic       shutdown_out
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  chk_reset_midscale: assert property (
    $rose(nrst_in) |-> wiper_reg_1_out == ipt_pkg::WIPER_MIDSCALE
      && wiper_reg_2_out == ipt_pkg::WIPER_MIDSCALE) else $error("wiper not midscale");
  chk_open_drain: assert property (
    sda_oe_out |-> !sda_out) else $error("sda driven high");
  chk_pin_shut: assert property (
    (en_in && nrst_in && !shutdown_pin_n_in) [*4] |-> shutdown_out)
    else $error("pin shutdown lost");
  chk_pin_wake: assert property (
    $fell(shutdown_out) |-> $past(shutdown_pin_n_in, 3)) else $error("woke with pin low");
  chk_oe_scl_low: assert property (
    $changed(sda_oe_out) |-> !($past(scl_in) && $past(scl_in, 2) && $past(scl_in, 3)))
    else $error("sda moved with scl high");
  chk_ack_hold: assert property (
    $rose(sda_oe_out) |-> sda_oe_out [*6]) else $error("ack too short");
  chk_wiper_quiet: assert property (
    $changed(wiper_reg_1_out) || $changed(wiper_reg_2_out) |-> !sda_oe_out)
    else $error("wiper moved during ack");
  chk_outs_quiet: assert property (
    $changed({logic_out_1_out, logic_out_2_out}) |-> !sda_oe_out)
    else $error("outputs moved during ack");
  cover property ($rose(sda_oe_out));
  cover property ($fell(shutdown_out));
  cover property ($changed(wiper_reg_2_out));
endmodule
bind ipt_pot_slave ipt_pot_slave_sva u_sva (.*);

// >>> test/ipt_bus_master.sv
// two-wire bus master model for the potentiometer slave bench
`timescale 1ns/100ps
module ipt_bus_master (
  // clock and bus
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // start when stop is low, stop when high; scl idles high after a stop
  task automatic frame(input logic stop);
    wt(1);
    sda_oe_out <= stop;
    wt(3);
    scl_out <= 1'b1;
    wt(4);
    sda_oe_out <= !stop;
    wt(4);
    scl_out <= stop;
  endtask
  // sda moves a cycle after scl falls, so no false start or stop
  task automatic bits(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      wt(1);
      sda_oe_out <= !tx[i];
      wt(3);
      scl_out <= 1'b1;
      wt(4);
      rx[i] = sda_in;
      scl_out <= 1'b0;
    end
  endtask
endmodule

// >>> test/tb_top.sv
// self-checking bench for the potentiometer command slave
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic [2:0] src;
    logic [8:0] val;
  } ipt_note_t;
  logic        clk, nrst, en, hi, lo, pin_n, scl, m_oe, d_sda, d_oe, lo1, lo2, sd, bad;
  logic        sdb, o1, o2;
  logic [7:0]  w1, w2, ins, dat;
  logic [7:0]  wm [2];
  logic [8:0]  rx, seen;
  logic [2:0]  ak;
  logic [31:0] r;
  int          seed = 92, bad_count = 0, checked = 0, cyc = 0;
  ipt_note_t   q[$], n;
  event        done;
  string       nm [5] = '{"wiper1", "wiper2", "outs", "read", "acks"};
  wire         sda = !(m_oe | d_oe);
  ipt_pot_slave dut (.clk_in(clk), .nrst_in(nrst), .en_in(en), .scl_in(scl), .sda_in(sda),
    .sda_out(d_sda), .sda_oe_out(d_oe), .addr_strap_hi_in(hi), .addr_strap_lo_in(lo),
    .shutdown_pin_n_in(pin_n), .wiper_reg_1_out(w1), .wiper_reg_2_out(w2),
    .logic_out_1_out(lo1), .logic_out_2_out(lo2), .shutdown_out(sd));
  ipt_bus_master bm (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string s, input logic [8:0] v, input logic [8:0] e);
    checked++;
    if (v !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic note(input logic [2:0] s, input logic [8:0] v);
    q.push_back({s, v});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial forever begin
    @(done);
    #1;
    while (q.size() > 0) begin
      n = q.pop_front();
      case (n.src)
        3'h0: seen = {1'b0, w1};
        3'h1: seen = {1'b0, w2};
        3'h2: seen = {6'h00, sd, lo1, lo2};
        3'h3: seen = rx;
        default: seen = {6'h00, ak};
      endcase
      chk(nm[n.src], seen, n.val);
    end
    chk("sda_drive", {8'h00, d_sda}, 9'h000);
  end
  initial begin
    nrst = 1'b0;
    en = 1'b1;
    hi = 1'b0;
    lo = 1'b0;
    pin_n = 1'b1;
    wm[0] = ipt_pkg::WIPER_MIDSCALE;
    wm[1] = ipt_pkg::WIPER_MIDSCALE;
    {sdb, o1, o2} = 3'h0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      bad = (k == 5);
      // freeze only while the bus idles, so no bus edge is lost
      en <= 1'b0;
      bm.wt(1 + r[26:25]);
      en <= 1'b1;
      hi <= r[2];
      lo <= r[1];
      pin_n <= r[0];
      ins = r[15:8];
      ins[7] = k[0];
      ins[6] = (k == 2) || (k == 7);
      dat = r[23:16];
      bm.wt(8);
      if (k == 4) begin
        // mid-run reset: wipers back to midscale, latches cleared
        nrst <= 1'b0;
        bm.wt(3);
        nrst <= 1'b1;
        bm.wt(4);
        wm[0] = ipt_pkg::WIPER_MIDSCALE;
        wm[1] = ipt_pkg::WIPER_MIDSCALE;
        {sdb, o1, o2} = 3'h0;
        note(3'h0, {1'b0, wm[0]});
        note(3'h1, {1'b0, wm[1]});
        note(3'h2, {6'h00, !r[0], 2'b00});
        -> done;
        bm.wt(2);
      end
      bm.frame(1'b0);
      bm.bits({ipt_pkg::ADDR_FIXED, r[2] ^ bad, r[1], 1'b0, 1'b1}, rx);
      ak[2] = rx[0];
      bm.bits({ins, 1'b1}, rx);
      ak[1] = rx[0];
      bm.bits({dat, 1'b1}, rx);
      ak[0] = rx[0];
      if (k == 3) begin
        // a second data byte lands in the same wiper
        dat = ~dat;
        bm.bits({dat, 1'b1}, rx);
        ak[0] = ak[0] | rx[0];
      end
      if (!bad) begin
        wm[ins[7]] = ins[6] ? ipt_pkg::WIPER_MIDSCALE : dat;
        {sdb, o1, o2} = ins[5:3];
      end
      note(3'h4, {6'h00, {3{bad}}});
      note(3'h0, {1'b0, wm[0]});
      note(3'h1, {1'b0, wm[1]});
      note(3'h2, {6'h00, sdb | !r[0], o1, o2});
      -> done;
      // odd tests go on to the read with a repeated start
      if (!k[0]) begin
        bm.frame(1'b1);
        bm.wt(8);
      end
      bm.frame(1'b0);
      bm.bits({ipt_pkg::ADDR_FIXED, r[2] ^ bad, r[1], 1'b1, 1'b1}, rx);
      bm.bits(9'h1fe, rx);
      note(3'h3, bad ? 9'h1fe : {wm[ins[7]], 1'b0});
      -> done;
      bm.bits(9'h1ff, rx);
      bm.frame(1'b1);
      note(3'h3, bad ? 9'h1ff : {wm[ins[7]], 1'b1});
      -> done;
      bm.wt(2);
      $display("test %0d done", k);
    end
    end_of_test();
  end
endmodule
